// [core/dram_powerdown_termination_ctrl.sv]
// termination control and power-down sequencing of the memory device
// assumes the command decoder upstream supplies one decoded command per
// clock and the mode field; the termination pin arrives asynchronously
// Summary of operation
// - option bit clear: power-down entry drops pin control, off in window
// - power-down exit restores termination within window, pin control after it
// - option bit set with nonzero field keeps pin control during power down
// - self refresh forces termination off, back on within window after exit
// - deep power down forces termination off within the disable window
// - command/address training holds termination off, pin ignored
// - data termination only for writes, strobe for writes and leveling
// - termination needs nonzero field and pin high; pin high in leveling
// - read turns termination off two cycles before latency, on after burst
// - power-down entered when clock enable low and chip select high
// - exit on clock enable high with chip select high, command after latency
// - no refresh in power down; idle or active power down reported
// - clock change with enable high needs idle bus, ready after 2tCK+exit; not handled here, cmd_accept ignores clock changes
// - no-op needs stable enable: chip select high, or low with CA0-2 high
`timescale 1ns/1ps
`include "term_consts.svh"
module dram_powerdown_termination_ctrl #(
   parameter int READ_LATENCY  = 12,
   parameter int BURST_LENGTH  = 8
) (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // command pins and decoded command
   input  wire term_pkg::cmd_pins_type pins,
   input  wire term_pkg::cmd_type      cmd,
   input  wire logic                   any_bank_open,
   // termination mode field and pin
   input  wire logic [2:0]             termination_mode_reg,
   input  wire logic                   termination_control_pin,
   // outputs
   output      term_pkg::term_out_type term_out,
   output      logic [1:0]             termination_resistance,
   output      logic                   receivers_on,
   output      logic                   cmd_accept,
   output      logic                   nop_valid,
   output      logic                   active_powerdown,
   output      logic                   refresh_allowed
);
   localparam int OFF_AT = READ_LATENCY - `READ_OFF_BEFORE_RL;
   localparam int ON_AT  = READ_LATENCY + BURST_LENGTH / 2;
   localparam int RCW    = $clog2(ON_AT + 2);

   // refused at elaboration: the read window needs room before latency
   if (READ_LATENCY <= `READ_OFF_BEFORE_RL ||
       BURST_LENGTH < 2) begin : g_bad_cfg
      $error("read latency or burst length out of range");
   end

   // ************************************************
   // pin synchroniser
   // ************************************************
   logic pin_meta_reg;
   logic pin_sync_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= termination_control_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ************************************************
   // command qualification
   // ************************************************
   logic cke_prev_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) cke_prev_reg <= 1'b1;
      else     cke_prev_reg <= pins.cke;
   end

   // chip select high, or low with CA0-2 high, is a no-op only while clock enable holds
   function automatic logic is_nop(input term_pkg::cmd_pins_type p,
                                   input logic cke_prev);
      return (p.cke == cke_prev) &&
             (p.cs_n || (p.ca_low == 3'h7));
   endfunction : is_nop

   logic nop_now;
   assign nop_now = is_nop(pins, cke_prev_reg);

   // ************************************************
   // power state machine
   // ************************************************
   term_pkg::power_state_type state_reg;
   term_pkg::power_state_type state_next;
   logic [7:0] timer_reg;
   logic [7:0] timer_next;

   always_comb begin
      state_next = state_reg;
      timer_next = (timer_reg != 8'h00) ? timer_reg - 8'h01 : 8'h00;
      unique case (state_reg)
         term_pkg::st_active: begin
            if (!pins.cke && cke_prev_reg && pins.cs_n) begin
               state_next = term_pkg::st_pd_entry;
               timer_next = 8'(`PD_ENTRY_DELAY_CYC);
            end else if (cmd == term_pkg::cmd_sref_enter) begin
               state_next = term_pkg::st_sref;
            end else if (cmd == term_pkg::cmd_dpd_enter) begin
               state_next = term_pkg::st_dpd;
            end
         end
         term_pkg::st_pd_entry: begin
            if (timer_reg <= 8'h01) state_next = term_pkg::st_pd;
         end
         term_pkg::st_pd: begin
            if (pins.cke && pins.cs_n) begin
               state_next = term_pkg::st_pd_exit;
               timer_next = 8'(`PD_EXIT_LAT_CYC);
            end
         end
         term_pkg::st_pd_exit: begin
            if (timer_reg <= 8'h01) state_next = term_pkg::st_active;
         end
         term_pkg::st_sref: begin
            if (cmd == term_pkg::cmd_sref_exit)
               state_next = term_pkg::st_active;
         end
         term_pkg::st_dpd: begin
            // left only through reset and reinitialization
            state_next = term_pkg::st_dpd;
         end
         default: state_next = term_pkg::st_active;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= term_pkg::st_active;
         timer_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
      end
   end

   // ************************************************
   // training modes and read window
   // ************************************************
   logic ca_train_reg;
   logic wr_level_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ca_train_reg <= 1'b0;
         wr_level_reg <= 1'b0;
      end else begin
         if (cmd == term_pkg::cmd_ca_train_on)       ca_train_reg <= 1'b1;
         else if (cmd == term_pkg::cmd_ca_train_off) ca_train_reg <= 1'b0;
         if (cmd == term_pkg::cmd_wr_level_on)       wr_level_reg <= 1'b1;
         else if (cmd == term_pkg::cmd_wr_level_off) wr_level_reg <= 1'b0;
      end
   end

   // counter restarts on each read so back-to-back reads extend the gap
   logic [RCW-1:0] read_cnt_reg;
   logic           read_busy_reg;
   logic           read_off_reg;
   logic           is_read;
   assign is_read = (cmd == term_pkg::cmd_read) ||
                    (cmd == term_pkg::cmd_mode_read);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         read_cnt_reg  <= '0;
         read_busy_reg <= 1'b0;
      end else if (is_read && state_reg == term_pkg::st_active) begin
         read_cnt_reg  <= RCW'(1);
         read_busy_reg <= 1'b1;
      end else if (read_busy_reg) begin
         read_cnt_reg  <= read_cnt_reg + RCW'(1);
         if (read_cnt_reg == RCW'(ON_AT)) read_busy_reg <= 1'b0;
      end
   end
   assign read_off_reg = read_busy_reg &&
                         (read_cnt_reg >= RCW'(OFF_AT));

   logic write_busy_reg;
   logic [RCW-1:0] write_cnt_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         write_busy_reg <= 1'b0;
         write_cnt_reg  <= '0;
      end else if (cmd == term_pkg::cmd_write) begin
         write_busy_reg <= 1'b1;
         write_cnt_reg  <= '0;
      end else if (write_busy_reg) begin
         write_cnt_reg <= write_cnt_reg + RCW'(1);
         if (write_cnt_reg == RCW'(ON_AT)) write_busy_reg <= 1'b0;
      end
   end

   // ************************************************
   // termination decision and windows
   // ************************************************
   logic [7:0] win_reg;
   logic       term_gate_reg;
   logic       want_on;
   logic       mode_on;
   logic       pd_blocks;
   assign mode_on   = termination_mode_reg[`MODE_RES_MSB:`MODE_RES_LSB]
                      != 2'b00;
   assign pd_blocks = (state_reg == term_pkg::st_pd_entry ||
                       state_reg == term_pkg::st_pd) &&
                      !termination_mode_reg[`MODE_PD_TERM_BIT];
   always_comb begin
      want_on = mode_on && pin_sync_reg;
      if (pd_blocks) want_on = 1'b0;
      if (state_reg == term_pkg::st_sref ||
          state_reg == term_pkg::st_dpd) want_on = 1'b0;
      if (ca_train_reg || read_off_reg ||
          cmd == term_pkg::cmd_calibrate) want_on = 1'b0;
   end

   // turn-off lands inside the window, after TERM_DISABLE_CYC cycles rounded down; turn-on likewise
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         win_reg       <= 8'h00;
         term_gate_reg <= 1'b0;
      end else if (want_on == term_gate_reg) begin
         win_reg <= 8'h00;
      end else if (win_reg >= 8'((want_on ? `TERM_ENABLE_CYC
                                          : `TERM_DISABLE_CYC) - 1)) begin
         term_gate_reg <= want_on;
         win_reg       <= 8'h00;
      end else begin
         win_reg <= win_reg + 8'h01;
      end
   end

   // ************************************************
   // output registers
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         term_out               <= '0;
         termination_resistance <= 2'b00;
         receivers_on           <= 1'b1;
         cmd_accept             <= 1'b1;
         nop_valid              <= 1'b0;
         active_powerdown       <= 1'b0;
         refresh_allowed        <= 1'b1;
      end else begin
         term_out.dq_term_on  <= term_gate_reg && want_on &&
                                 write_busy_reg && !wr_level_reg;
         term_out.dqs_term_on <= term_gate_reg && want_on &&
                                 (write_busy_reg || wr_level_reg);
         termination_resistance <=
            termination_mode_reg[`MODE_RES_MSB:`MODE_RES_LSB];
         receivers_on <= state_next == term_pkg::st_active ||
                         state_next == term_pkg::st_pd_entry;
         cmd_accept   <= state_next == term_pkg::st_active;
         nop_valid    <= nop_now;
         if (state_next == term_pkg::st_pd_entry)
            active_powerdown <= any_bank_open;
         refresh_allowed <= state_next == term_pkg::st_active ||
                            state_next == term_pkg::st_sref;
      end
   end
endmodule : dram_powerdown_termination_ctrl

// [core/term_consts.svh]
// timing counts and field positions for the termination/power-down block
// assumes a 200 MHz system clock driving every register
`ifndef TERM_CONSTS_SVH
`define TERM_CONSTS_SVH
`define CLK_PERIOD_PS          5000
// termination disable / enable windows (max), picoseconds
`define TERM_DISABLE_WIN_PS    12000
`define TERM_ENABLE_WIN_PS     12000
`define TERM_DISABLE_CYC       ((`TERM_DISABLE_WIN_PS) / (`CLK_PERIOD_PS))
`define TERM_ENABLE_CYC        ((`TERM_ENABLE_WIN_PS) / (`CLK_PERIOD_PS))
// entry delay in cycles (two no-operation commands)
`define PD_ENTRY_DELAY_CYC     2
// power-down exit latency, picoseconds, least time rounds up
`define PD_EXIT_LAT_PS         7500
`define PD_EXIT_LAT_CYC        \
   (((`PD_EXIT_LAT_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
// mode field positions
`define MODE_PD_TERM_BIT       2
`define MODE_RES_MSB           1
`define MODE_RES_LSB           0
// read window turn-off offset, cycles before read latency
`define READ_OFF_BEFORE_RL     2
`endif

// [core/term_pkg.sv]
// types for the termination/power-down block
// assumes term_consts.svh supplies the numbers
package term_pkg;
   // command decoded at a rising edge
   typedef enum logic [3:0] {
      cmd_none_type_e  = 4'h0,
      cmd_nop          = 4'h1,
      cmd_read         = 4'h2,
      cmd_write        = 4'h3,
      cmd_mode_read    = 4'h4,
      cmd_sref_enter   = 4'h5,
      cmd_sref_exit    = 4'h6,
      cmd_dpd_enter    = 4'h7,
      cmd_ca_train_on  = 4'h8,
      cmd_ca_train_off = 4'h9,
      cmd_wr_level_on  = 4'hA,
      cmd_wr_level_off = 4'hB,
      cmd_calibrate    = 4'hC,
      cmd_other        = 4'hD
   } cmd_type;

   // power states, gray along active -> pd_entry -> pd -> pd_exit
   typedef enum logic [2:0] {
      st_active   = 3'h0,
      st_pd_entry = 3'h1,
      st_pd       = 3'h3,
      st_pd_exit  = 3'h2,
      st_sref     = 3'h6,
      st_dpd      = 3'h7
   } power_state_type;

   typedef struct packed {
      logic       cs_n;
      logic       cke;
      logic [2:0] ca_low;
   } cmd_pins_type;

   typedef struct packed {
      logic dq_term_on;
      logic dqs_term_on;
   } term_out_type;
endpackage : term_pkg

// [sim/ctrl_model.sv]
// memory controller model driving chip select, clock enable and commands
// assumes the bench calls its tasks; pins change at falling edges
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic             clk_sys,
   output term_pkg::cmd_pins_type pins,
   output term_pkg::cmd_type      cmd
);
   initial begin
      pins = '{cs_n: 1'b1, cke: 1'b1, ca_low: 3'h7};
      cmd = term_pkg::cmd_nop;
   end
   // ********
   // command tasks
   // ********
   task issue(input term_pkg::cmd_type c);
      @(negedge clk_sys);
      pins.cs_n = 1'b0;
      pins.ca_low = 3'($urandom_range(6));
      cmd = c;
   endtask : issue
   // either encoding, clock enable left alone
   task no_operation_cmd(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         pins.cs_n = 1'($urandom);
         pins.ca_low = pins.cs_n ? 3'($urandom) : 3'h7;
         cmd = term_pkg::cmd_nop;
      end
   endtask : no_operation_cmd
   // ignored pins keep moving so stale values cannot pass for real ones
   task pd_enter(input int n);
      @(negedge clk_sys);
      pins.cke = 1'b0;
      pins.cs_n = 1'b1;
      cmd = term_pkg::cmd_nop;
      repeat (n) begin
         @(negedge clk_sys);
         pins.ca_low = 3'($urandom);
      end
   endtask : pd_enter
   // clock already running steadily well before this edge
   task pd_exit();
      @(negedge clk_sys);
      pins.cke = 1'b1;
      pins.cs_n = 1'b1;
   endtask : pd_exit
endmodule : ctrl_model

// [sim/tb_top.sv]
// self-checking bench for the termination and power-down block
// assumes the controller model drives the command pins
`timescale 1ns/1ps
`define CHECK(act, exp) \
   begin \
      comparisons++; \
      if ((act) !== (exp)) begin \
         miscompares++; \
         $display("[FAIL] %0t got %h expected %h", $time, act, exp); \
      end \
   end
module tb_top;
   localparam int READ_LAT  = 6;
   localparam int BURST_LEN = 8;
   logic                   clk_sys = 1'b0;
   logic                   rst;
   logic                   any_bank_open;
   logic [2:0]             mode;
   logic                   pin;
   logic [1:0]             cke_hist = 2'h3;
   logic [1:0]             exp_res = 2'h0;
   logic                   exp_nop = 1'b0;
   logic                   live = 1'b0;
   logic                   on;
   term_pkg::cmd_pins_type pins;
   term_pkg::cmd_type      cmd;
   term_pkg::term_out_type term_out;
   logic [1:0]             termination_resistance;
   logic                   receivers_on;
   logic                   cmd_accept;
   logic                   nop_valid;
   logic                   active_powerdown;
   logic                   refresh_allowed;
   int                     miscompares = 0;
   int                     comparisons = 0;
   always #2.5 clk_sys = ~clk_sys; // steady, never stopped
   ctrl_model u_ctrl (
      .clk_sys(clk_sys),
      .pins(pins),
      .cmd(cmd)
   );
   dram_powerdown_termination_ctrl #(
      .READ_LATENCY(READ_LAT),
      .BURST_LENGTH(BURST_LEN)
   ) u_dut (
      .clk_sys(clk_sys), .rst(rst), .pins(pins), .cmd(cmd),
      .any_bank_open(any_bank_open),
      .termination_mode_reg(mode),
      .termination_control_pin(pin),
      .term_out(term_out),
      .termination_resistance(termination_resistance),
      .receivers_on(receivers_on), .cmd_accept(cmd_accept),
      .nop_valid(nop_valid), .active_powerdown(active_powerdown),
      .refresh_allowed(refresh_allowed)
   );
   // ********
   // reference model: resistance compared every cycle, no-op flag only when active with clock enable held high
   // ********
   always @(posedge clk_sys) begin
      live <= !rst;
      exp_res <= mode[1:0];
      exp_nop <= pins.cke == cke_hist[0] && (pins.cs_n || pins.ca_low == 3'h7);
      cke_hist <= {cke_hist[0], pins.cke};
   end
   always @(negedge clk_sys) begin
      if (live) begin
         `CHECK(termination_resistance, exp_res)
         if (cke_hist == 2'h3 && receivers_on === 1'b1 &&
             cmd_accept === 1'b1) begin
            `CHECK(nop_valid, exp_nop)
         end
      end
   end
   task summarize();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   // write, compare termination with the expected value, then wait a settle time
   task wr_check(input logic [1:0] exp);
      u_ctrl.issue(term_pkg::cmd_write);
      u_ctrl.no_operation_cmd(6);
      `CHECK(term_out, exp)
      u_ctrl.no_operation_cmd(10);
   endtask : wr_check
   // ********
   // scenarios
   // ********
   initial begin
      rst = 1'b1;
      any_bank_open = 1'b0;
      mode = 3'h1;
      pin = 1'b1;
      void'($urandom(32'hA1B5));
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHECK({receivers_on, cmd_accept, refresh_allowed}, 3'h7)
      `CHECK({term_out, nop_valid, active_powerdown}, 4'h0)
      rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         mode = i[2:0];
         pin = i[3];
         on = pin && (mode[1:0] != 2'h0);
         u_ctrl.no_operation_cmd(4);
         wr_check({on, on});
         `CHECK(term_out, 2'h0)
      end
      mode = 3'h1;
      pin = 1'b1; // held high while leveling
      u_ctrl.issue(term_pkg::cmd_wr_level_on);
      u_ctrl.no_operation_cmd(6);
      `CHECK(term_out, 2'h1)
      u_ctrl.issue(term_pkg::cmd_wr_level_off);
      u_ctrl.issue(term_pkg::cmd_ca_train_on);
      wr_check(2'h0);
      u_ctrl.issue(term_pkg::cmd_ca_train_off);
      u_ctrl.no_operation_cmd(4);
      for (int k = 0; k < 2; k++) begin
         u_ctrl.issue(term_pkg::cmd_write);
         u_ctrl.no_operation_cmd(2);
         u_ctrl.issue(k == 0 ? term_pkg::cmd_read : term_pkg::cmd_mode_read);
         u_ctrl.no_operation_cmd(READ_LAT + 1);
         `CHECK(term_out, 2'h0)
         u_ctrl.no_operation_cmd(12); // enable held past burst and recovery
      end
      // calibration drops termination for its own cycle only
      u_ctrl.issue(term_pkg::cmd_write);
      u_ctrl.no_operation_cmd(2);
      u_ctrl.issue(term_pkg::cmd_calibrate);
      u_ctrl.no_operation_cmd(1);
      `CHECK(term_out, 2'h0)
      u_ctrl.no_operation_cmd(1);
      `CHECK(term_out, 2'h3)
      u_ctrl.no_operation_cmd(12); // hold and mode write times kept
      for (int b = 0; b < 2; b++) begin
         any_bank_open = b[0];
         u_ctrl.pd_enter(6);
         `CHECK({receivers_on, refresh_allowed}, 2'h0)
         `CHECK(active_powerdown, b[0])
         `CHECK(term_out, 2'h0)
         u_ctrl.pd_exit();
         u_ctrl.no_operation_cmd(1);
         `CHECK(cmd_accept, 1'b0)
         u_ctrl.no_operation_cmd(4);
         `CHECK(cmd_accept, 1'b1)
         wr_check(2'h3);
      end
      u_ctrl.issue(term_pkg::cmd_sref_enter);
      wr_check(2'h0);
      u_ctrl.issue(term_pkg::cmd_sref_exit);
      u_ctrl.no_operation_cmd(3);
      wr_check(2'h3);
      u_ctrl.issue(term_pkg::cmd_dpd_enter);
      wr_check(2'h0);
      rst = 1'b1; // full initialization to leave deep power down
      u_ctrl.no_operation_cmd(2);
      rst = 1'b0;
      u_ctrl.no_operation_cmd(2);
      wr_check(2'h3);
      summarize();
   end
endmodule : tb_top

// [sim/term_pd_monitor.sv]
// assertion checker for the termination and power-down block
// assumes it is bound onto the block and sees only its ports
`timescale 1ns/1ps
module term_pd_monitor #(
   parameter int READ_LATENCY = 12,
   parameter int BURST_LENGTH = 8
) (
   input wire logic                   clk_sys,
   input wire logic                   rst,
   input wire term_pkg::cmd_pins_type pins,
   input wire term_pkg::cmd_type      cmd,
   input wire logic                   any_bank_open,
   input wire logic [2:0]             termination_mode_reg,
   input wire logic                   termination_control_pin,
   input wire term_pkg::term_out_type term_out,
   input wire logic [1:0]             termination_resistance,
   input wire logic                   receivers_on,
   input wire logic                   cmd_accept,
   input wire logic                   nop_valid,
   input wire logic                   active_powerdown,
   input wire logic                   refresh_allowed
);
   // inside the read turn-off window, output register lag included
   localparam int RD_MID = READ_LATENCY + 1;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ********
   // properties
   // ********
   sequence s_entry;
      $fell(pins.cke) && pins.cs_n && cmd_accept && receivers_on;
   endsequence
   property p_entry;
      s_entry |=> receivers_on ##[1:3] !receivers_on;
   endproperty
   a_entry: assert property (p_entry)
      else $error("receivers not off after entry delay");
   property p_exit;
      !receivers_on && $rose(pins.cke) && pins.cs_n |-> ##[1:4] cmd_accept;
   endproperty
   a_exit: assert property (p_exit)
      else $error("commands not accepted after exit latency");
   property p_pd_term;
      s_entry ##0 !termination_mode_reg[2] |-> ##3 term_out == 2'h0;
   endproperty
   a_pd_term: assert property (p_pd_term)
      else $error("termination on in power down");
   property p_active_pd;
      s_entry ##0 any_bank_open |-> ##[1:4] active_powerdown;
   endproperty
   a_active_pd: assert property (p_active_pd)
      else $error("active power down not flagged");
   property p_dq_dqs;
      term_out.dq_term_on |-> term_out.dqs_term_on;
   endproperty
   a_dq_dqs: assert property (p_dq_dqs)
      else $error("data termination without strobe termination");
   property p_res_gate;
      term_out != 2'h0 |-> termination_resistance != 2'h0;
   endproperty
   a_res_gate: assert property (p_res_gate)
      else $error("termination on with zero resistance field");
   property p_catrain;
      cmd == term_pkg::cmd_ca_train_on ##1
         (cmd != term_pkg::cmd_ca_train_off)[*4] |-> term_out == 2'h0;
   endproperty
   a_catrain: assert property (p_catrain)
      else $error("termination on during training");
   property p_sref;
      cmd == term_pkg::cmd_sref_enter && cmd_accept ##1
         (cmd != term_pkg::cmd_sref_exit)[*4] |-> term_out == 2'h0;
   endproperty
   a_sref: assert property (p_sref)
      else $error("termination on in self refresh");
   property p_dpd;
      cmd == term_pkg::cmd_dpd_enter && cmd_accept
         |-> ##3 (term_out == 2'h0)[*4];
   endproperty
   a_dpd: assert property (p_dpd)
      else $error("termination on in deep power down");
   property p_read_off;
      cmd == term_pkg::cmd_read && cmd_accept |-> ##RD_MID term_out == 2'h0;
   endproperty
   a_read_off: assert property (p_read_off)
      else $error("termination on inside read window");
   property p_nop;
      $changed(pins.cke) || (!pins.cs_n && pins.ca_low != 3'h7)
         |=> !nop_valid;
   endproperty
   a_nop: assert property (p_nop)
      else $error("invalid no-operation flagged");
   c_entry: cover property (s_entry);
   c_read: cover property (cmd == term_pkg::cmd_read && cmd_accept);
   c_exit: cover property ($rose(cmd_accept));
endmodule : term_pd_monitor

bind dram_powerdown_termination_ctrl term_pd_monitor #(
   .READ_LATENCY(READ_LATENCY),
   .BURST_LENGTH(BURST_LENGTH)
) u_monitor (
   .clk_sys(clk_sys), .rst(rst), .pins(pins), .cmd(cmd),
   .any_bank_open(any_bank_open),
   .termination_mode_reg(termination_mode_reg),
   .termination_control_pin(termination_control_pin),
   .term_out(term_out),
   .termination_resistance(termination_resistance),
   .receivers_on(receivers_on), .cmd_accept(cmd_accept),
   .nop_valid(nop_valid), .active_powerdown(active_powerdown),
   .refresh_allowed(refresh_allowed)
);
